// ===== common/spm_link_if.sv
// Bit-slot level link between the bus master and the memory device
`timescale 1ns/1ps
interface spm_link_if
(
  input wire logic clk_sys,
  input wire logic rstn
);
  // Master to device
  logic rst_pulse;         // Reset pulse, one cycle
  logic rst_regular;       // Reset sent at regular speed, ends overdrive
  logic rom_done;          // ROM function command completed, one cycle
  logic rom_od;            // That ROM command was an overdrive one
  logic slot_req;          // Time slot start, one cycle
  logic slot_wr;           // 1 write slot, 0 read slot
  logic slot_bit;          // Bit written in a write slot
  // Device to master
  logic presence;          // Presence answer, one cycle
  logic slot_done;         // Slot finished, one cycle
  logic rd_bit;            // Level of the line in that slot
  logic overdrive_select;  // Device speed state
  // Device end
  modport dev
  (
    input  rst_pulse, rst_regular, rom_done, rom_od, slot_req, slot_wr, slot_bit,
    output presence, slot_done, rd_bit, overdrive_select
  );
  // Master end
  modport mst
  (
    output rst_pulse, rst_regular, rom_done, rom_od, slot_req, slot_wr, slot_bit,
    input  presence, slot_done, rd_bit, overdrive_select
  );
endinterface

// ===== common/spm_pkg.sv
// Shared constants for the scratchpad memory command engine and its bus master
package spm_pkg;
  // ==========================================================================
  // Memory geometry
  localparam int SP_BYTES    = 32;         // Scratchpad page size
  localparam int MEM_PAGES   = 16;         // Data pages in main memory
  localparam int MEM_BYTES   = 512;        // Main memory size
  // ==========================================================================
  // Memory function command codes
  localparam logic [7:0] CMD_WRITE_SP = 8'h0F;
  localparam logic [7:0] CMD_READ_SP  = 8'hAA;
  localparam logic [7:0] CMD_COPY_SP  = 8'h5A;
  localparam logic [7:0] CMD_READ_MEM = 8'hF0;
  // ==========================================================================
  // Ending-status field positions and reset values
  localparam int ES_AA_BIT   = 7;          // Copy accepted flag
  localparam int ES_ZERO_BIT = 6;          // Always reads zero
  localparam int ES_PF_BIT   = 5;          // Partial byte flag
  localparam int ES_OFF_MSB  = 4;          // Ending offset bits 4:0
  localparam logic [7:0] TA_RST     = 8'h00;
  localparam logic [7:0] ES_RST     = 8'h00;
  localparam logic [4:0] OFF_LAST   = 5'h1F;  // Scratchpad full offset
  localparam logic [7:0] FILL_BYTE  = 8'hFF;  // Idle bus reads as ones
  // ==========================================================================
  // CRC16 generator, reflected form, shifted LSB first
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [15:0] CRC_INIT = 16'h0000;
  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int COPY_TIME_NS  = 30000;    // Typical copy duration
  localparam int COPY_CYC      = (COPY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRES_WAIT_CYC = 16;       // Master wait for presence answer
endpackage

// ===== rtl/spm_device.sv
// Memory device end: scratchpad, main memory and memory function commands
`timescale 1ns/1ps
module spm_device
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Link to the bus master
  spm_link_if.dev  link,
  // User side: state for observation
  output logic [7:0] target_address_low,
  output logic [7:0] target_address_high,
  output logic [7:0] ending_offset_status,
  output logic       copy_busy
);
  // ==========================================================================
  // Types
  typedef enum logic [3:0]
  {
    S_IDLE  = 4'b0000,  // After reset, waiting for ROM command
    S_CMD   = 4'b0001,  // Receiving command code
    S_ADLO  = 4'b0010,  // Receiving address low byte
    S_ADHI  = 4'b0011,  // Receiving address high byte
    S_WDATA = 4'b0100,  // Receiving scratchpad data
    S_WCRC  = 4'b0101,  // Sending inverted CRC16
    S_RSP   = 4'b0110,  // Sending scratchpad preamble and data
    S_AUTH  = 4'b0111,  // Receiving copy authorization
    S_COPY  = 4'b1000,  // Copy in progress
    S_CDONE = 4'b1001,  // Sending alternating pattern
    S_RMEM  = 4'b1010,  // Sending main memory
    S_IGN   = 4'b1011   // Dead until next reset pulse
  } spm_dst_e;

  typedef struct packed
  {
    spm_dst_e    st;        // Command state
    logic [7:0]  sh;        // Receive shift register
    logic [2:0]  bc;        // Bit count within byte
    logic [7:0]  tx;        // Byte being sent
    logic [7:0]  cmd;       // Current command code
    logic [7:0]  ta_lo;     // Target address low
    logic [7:0]  ta_hi;     // Target address high
    logic [7:0]  es;        // Ending offset and status
    logic [15:0] crc;       // CRC16 accumulator
    logic [5:0]  ptr;       // Scratchpad offset, bit 5 marks past end
    logic [1:0]  ph;        // Preamble or authorization byte index
    logic [9:0]  maddr;     // Memory read address, bit 9 marks past end
    logic [8:0]  timer;     // Copy duration counter
    logic [5:0]  cpo;       // Copy offset
    logic        tog;       // Alternating pattern bit
    logic        presence;  // Presence pulse
    logic        done;      // Slot done pulse
    logic        rd;        // Line level of last slot
    logic        od;        // Overdrive select
    logic        busy;      // Copy running, kept in a flop for the output
  } spm_dev_s;

  // ==========================================================================
  // Storage: main memory and scratchpad, not reset like real SRAM
  // sixteen pages plus scratchpad
  logic [7:0] mem_q [spm_pkg::MEM_BYTES];
  logic [7:0] sp_q  [spm_pkg::SP_BYTES];

  spm_dev_s   r_q;      // Registered state
  spm_dev_s   r_d;      // Next state
  logic       sp_we;    // Scratchpad write strobe
  logic [4:0] sp_wa;    // Scratchpad write offset
  logic [7:0] sp_wd;    // Scratchpad write data
  logic       mem_we;   // Memory write strobe
  logic [8:0] mem_wa;   // Memory write address
  logic [7:0] mem_wd;   // Memory write data

  // ==========================================================================
  // Checks on the memory geometry
  initial
  begin
    if (spm_pkg::MEM_BYTES != spm_pkg::MEM_PAGES * spm_pkg::SP_BYTES)
    begin
      $error("Memory size must be pages times page size");
    end
  end

  // One CRC16 step for one bit
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    if (c[0] ^ b)
    begin
      crc_step = (c >> 1) ^ spm_pkg::CRC_POLY;
    end
    else
    begin
      crc_step = c >> 1;
    end
  endfunction

  // ==========================================================================
  // Next-state logic
  always_comb
  begin
    logic [7:0] byt;
    logic       bdone;
    byt    = {link.slot_bit, r_q.sh[7:1]};
    bdone  = (r_q.bc == 3'h7);
    r_d    = r_q;
    r_d.presence = 1'b0;
    r_d.done     = 1'b0;
    sp_we  = 1'b0;
    sp_wa  = r_q.ptr[4:0];
    sp_wd  = byt;
    mem_we = 1'b0;
    mem_wa = {r_q.ta_hi[0], r_q.ta_lo[7:5], r_q.cpo[4:0]};
    mem_wd = sp_q[r_q.cpo[4:0]];
    r_d.es[spm_pkg::ES_ZERO_BIT] = 1'b0;

    if (link.slot_req)
    begin
      r_d.done = 1'b1;
      if (link.slot_wr)
      begin
        // Write slot: the line shows the bit the master drives
        r_d.rd = link.slot_bit;
        r_d.sh = byt;
        r_d.bc = r_q.bc + 3'h1;
        if ((r_q.st == S_CMD) || (r_q.st == S_ADLO) || (r_q.st == S_ADHI) ||
            (r_q.st == S_WDATA))
        begin
          r_d.crc = crc_step(r_q.crc, link.slot_bit);
        end
        if (bdone)
        begin
          unique case (r_q.st)
            S_CMD:
            begin
              r_d.cmd = byt;
              if ((byt == spm_pkg::CMD_WRITE_SP) || (byt == spm_pkg::CMD_READ_MEM))
              begin
                r_d.st = S_ADLO;
              end
              else if (byt == spm_pkg::CMD_READ_SP)
              begin
                r_d.st  = S_RSP;
                r_d.tx  = r_q.ta_lo;
                r_d.ph  = 2'h1;
                r_d.ptr = {1'b0, r_q.ta_lo[4:0]};
              end
              else if (byt == spm_pkg::CMD_COPY_SP)
              begin
                r_d.st = S_AUTH;
                r_d.ph = 2'h0;
              end
              else
              begin
                r_d.st = S_IGN;
              end
            end
            S_ADLO:
            begin
              r_d.ta_lo = byt;
              r_d.st    = S_ADHI;
            end
            S_ADHI:
            begin
              r_d.ta_hi = {7'h00, byt[0]};
              if (r_q.cmd == spm_pkg::CMD_WRITE_SP)
              begin
                r_d.ptr = {1'b0, r_q.ta_lo[4:0]};
                r_d.es[spm_pkg::ES_AA_BIT] = 1'b0;
                r_d.es[spm_pkg::ES_PF_BIT] = 1'b0;
                r_d.st = S_WDATA;
              end
              else
              begin
                r_d.maddr = {1'b0, byt[0], r_q.ta_lo};
                r_d.tx    = mem_q[{byt[0], r_q.ta_lo}];
                r_d.st    = S_RMEM;
              end
            end
            S_WDATA:
            begin
              // data stored from the offset onward
              sp_we = 1'b1;
              r_d.es[spm_pkg::ES_OFF_MSB:0] = r_q.ptr[4:0];
              if (r_q.ptr[4:0] == spm_pkg::OFF_LAST)
              begin
                r_d.st = S_WCRC;
                r_d.tx = ~r_d.crc[7:0];
                r_d.ph = 2'h0;
              end
              else
              begin
                r_d.ptr = r_q.ptr + 6'h01;
              end
            end
            S_AUTH:
            begin
              // exact match of all three bytes
              if (byt != ((r_q.ph == 2'h0) ? r_q.ta_lo :
                          (r_q.ph == 2'h1) ? r_q.ta_hi : r_q.es))
              begin
                r_d.st = S_IGN;
              end
              else if (r_q.ph == 2'h2)
              begin
                r_d.es[spm_pkg::ES_AA_BIT] = 1'b1;
                r_d.st    = S_COPY;
                r_d.timer = 9'h000;
                r_d.cpo   = {1'b0, r_q.ta_lo[4:0]};
              end
              else
              begin
                r_d.ph = r_q.ph + 2'h1;
              end
            end
            default:
            begin
              // Write slots in sending or dead states carry no meaning
            end
          endcase
        end
      end
      else
      begin
        // Read slot: LSB first from the byte being sent
        r_d.rd = 1'b1;
        if ((r_q.st == S_RSP) || (r_q.st == S_RMEM) || (r_q.st == S_WCRC))
        begin
          r_d.rd = r_q.tx[r_q.bc];
          r_d.bc = r_q.bc + 3'h1;
          if (bdone)
          begin
            if (r_q.st == S_RSP)
            begin
              // high address, status, data, then ones
              r_d.ph = (r_q.ph == 2'h3) ? 2'h3 : r_q.ph + 2'h1;
              if (r_q.ph == 2'h1)
              begin
                r_d.tx = r_q.ta_hi;
              end
              else if (r_q.ph == 2'h2)
              begin
                r_d.tx = r_q.es;
              end
              else
              begin
                r_d.tx  = r_q.ptr[5] ? spm_pkg::FILL_BYTE : sp_q[r_q.ptr[4:0]];
                r_d.ptr = r_q.ptr[5] ? r_q.ptr : r_q.ptr + 6'h01;
              end
            end
            else if (r_q.st == S_RMEM)
            begin
              // sequential data, ones past the end
              r_d.maddr = r_q.maddr[9] ? r_q.maddr : r_q.maddr + 10'h001;
              r_d.tx    = r_d.maddr[9] ? spm_pkg::FILL_BYTE : mem_q[r_d.maddr[8:0]];
            end
            else
            begin
              r_d.tx = (r_q.ph == 2'h0) ? ~r_q.crc[15:8] : spm_pkg::FILL_BYTE;
              r_d.ph = 2'h1;
            end
          end
        end
        else if (r_q.st == S_CDONE)
        begin
          r_d.rd  = r_q.tog;
          r_d.tog = ~r_q.tog;
        end
      end
    end

    // one byte a cycle, begin through ending offset
    if (r_q.st == S_COPY)
    begin
      r_d.timer = r_q.timer + 9'h001;
      if (!r_q.cpo[5] && (r_q.cpo[4:0] <= r_q.es[spm_pkg::ES_OFF_MSB:0]))
      begin
        mem_we = 1'b1;
        r_d.cpo = r_q.cpo + 6'h01;
      end
      if (r_q.timer == 9'(spm_pkg::COPY_CYC - 1))
      begin
        r_d.st  = S_CDONE;
        r_d.tog = 1'b1;
      end
    end

    // ROM command accepted only after reset
    if (link.rom_done && (r_q.st == S_IDLE))
    begin
      r_d.st  = S_CMD;
      r_d.bc  = 3'h0;
      r_d.crc = spm_pkg::CRC_INIT;
      r_d.od  = r_q.od | link.rom_od;
    end

    if (link.rst_pulse && (r_q.st != S_COPY))
    begin
      // unfinished byte sets the partial flag
      if ((r_q.st == S_WDATA) && (r_q.bc != 3'h0))
      begin
        r_d.es[spm_pkg::ES_PF_BIT] = 1'b1;
      end
      r_d.presence = 1'b1;
      r_d.st       = S_IDLE;
      r_d.bc       = 3'h0;
      if (link.rst_regular)
      begin
        r_d.od = 1'b0;
      end
    end
    // Busy flag registered so the user output comes straight from a flop
    r_d.busy = (r_d.st == S_COPY);
  end

  // ==========================================================================
  // State register; power-up waits for a first reset pulse
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      r_q       <= '0;
      r_q.st    <= S_IGN;
      r_q.ta_lo <= spm_pkg::TA_RST;
      r_q.ta_hi <= spm_pkg::TA_RST;
      r_q.es    <= spm_pkg::ES_RST;
      r_q.rd    <= 1'b1;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // Array writes kept apart: memories take no reset
  always_ff @(posedge clk_sys)
  begin
    if (sp_we)
    begin
      sp_q[sp_wa] <= sp_wd;
    end
    if (mem_we)
    begin
      mem_q[mem_wa] <= mem_wd;
    end
  end

  // ==========================================================================
  // Outputs, all straight from the state register
  assign link.presence         = r_q.presence;
  assign link.slot_done        = r_q.done;
  assign link.rd_bit           = r_q.rd;
  assign link.overdrive_select = r_q.od;
  assign target_address_low    = r_q.ta_lo;
  assign target_address_high   = r_q.ta_hi;
  assign ending_offset_status  = r_q.es;
  assign copy_busy             = r_q.busy;
endmodule

// ===== rtl/spm_master.sv
// Bus master end: reset, ROM step and LSB-first bit slots for user requests
`timescale 1ns/1ps
module spm_master
#(
  parameter int PRES_WAIT = spm_pkg::PRES_WAIT_CYC  // Cycles to wait for presence
)
(
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       rstn,
  // Link to the device
  spm_link_if.mst        link,
  // User requests
  input wire logic       req_valid,
  input wire logic [1:0] req_op,      // 0 reset+ROM, 1 write bits, 2 read bits
  input wire logic [7:0] req_data,
  input wire logic [3:0] req_nbits,   // 1 to 8 bits
  input wire logic       req_od,      // Reset keeps or enters overdrive
  output logic           req_ready,
  // User answers
  output logic           rsp_valid,
  output logic [7:0]     rsp_data,
  output logic           od_active
);
  // ==========================================================================
  // Types
  typedef enum logic [2:0]
  {
    H_IDLE = 3'b000,  // Ready for a request
    H_RST  = 3'b001,  // Send reset pulse
    H_PRES = 3'b010,  // Wait for presence
    H_ROM  = 3'b011,  // Signal ROM command done
    H_SLOT = 3'b100,  // Start a slot
    H_WAIT = 3'b101   // Wait slot end
  } spm_mst_e;

  typedef struct packed
  {
    spm_mst_e   st;
    logic [7:0] sh;       // Bits still to send
    logic [7:0] rx;       // Bits received
    logic [3:0] cnt;      // Slots left
    logic       wr;       // Write slots
    logic       od;       // Overdrive wanted
    logic [7:0] wait_c;   // Presence wait counter
    logic       ready;
    logic       rsp;
    logic       rst_p;
    logic       rom_p;
    logic       slot_p;
  } spm_mst_s;

  spm_mst_s r_q;
  spm_mst_s r_d;

  // ==========================================================================
  // Parameter checks
  initial
  begin
    if ((PRES_WAIT < 1) || (PRES_WAIT > 255))
    begin
      $error("PRES_WAIT must lie in 1 to 255");
    end
  end

  // ==========================================================================
  // Next-state logic
  always_comb
  begin
    r_d        = r_q;
    r_d.rsp    = 1'b0;
    r_d.rst_p  = 1'b0;
    r_d.rom_p  = 1'b0;
    r_d.slot_p = 1'b0;
    unique case (r_q.st)
      H_IDLE:
      begin
        if (req_valid && r_q.ready)
        begin
          r_d.ready = 1'b0;
          r_d.sh    = req_data;
          r_d.cnt   = (req_nbits == 4'h0) ? 4'h1 : req_nbits;
          r_d.wr    = (req_op == 2'h1);
          r_d.od    = req_od;
          r_d.st    = (req_op == 2'h0) ? H_RST : H_SLOT;
        end
      end
      H_RST:
      begin
        // every command sequence starts with reset
        r_d.rst_p  = 1'b1;
        r_d.wait_c = 8'h00;
        r_d.st     = H_PRES;
      end
      H_PRES:
      begin
        r_d.wait_c = r_q.wait_c + 8'h01;
        if (link.presence)
        begin
          r_d.st = H_ROM;
        end
        else if (r_q.wait_c == 8'(PRES_WAIT - 1))
        begin
          // no answer during copy, so retry
          r_d.st = H_RST;
        end
      end
      H_ROM:
      begin
        // ROM step done before memory commands
        r_d.rom_p = 1'b1;
        r_d.rx    = 8'h00;
        r_d.rsp   = 1'b1;
        r_d.ready = 1'b1;
        r_d.st    = H_IDLE;
      end
      H_SLOT:
      begin
        r_d.slot_p = 1'b1;
        r_d.st     = H_WAIT;
      end
      H_WAIT:
      begin
        if (link.slot_done)
        begin
          r_d.rx  = {link.rd_bit, r_q.rx[7:1]};
          r_d.sh  = {1'b1, r_q.sh[7:1]};
          r_d.cnt = r_q.cnt - 4'h1;
          if (r_q.cnt == 4'h1)
          begin
            r_d.rsp   = 1'b1;
            r_d.ready = 1'b1;
            r_d.st    = H_IDLE;
          end
          else
          begin
            r_d.st = H_SLOT;
          end
        end
      end
      default:
      begin
        r_d.st = H_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      r_q       <= '0;
      r_q.st    <= H_IDLE;
      r_q.ready <= 1'b1;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // ==========================================================================
  // Outputs from flops
  // regular-speed reset unless overdrive asked
  assign link.rst_pulse   = r_q.rst_p;
  assign link.rst_regular = ~r_q.od;
  assign link.rom_done    = r_q.rom_p;
  assign link.rom_od      = r_q.od;
  assign link.slot_req    = r_q.slot_p;
  assign link.slot_wr     = r_q.wr;
  assign link.slot_bit    = r_q.sh[0];
  assign req_ready        = r_q.ready;
  assign rsp_valid        = r_q.rsp;
  assign rsp_data         = r_q.rx;
  assign od_active        = link.overdrive_select;
endmodule

// ===== verification/spm_link_properties.sv
// Concurrent checks on the bit-slot link between master and device
`timescale 1ns/1ps
module spm_link_properties
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Link signals
  input wire logic rst_pulse,
  input wire logic rst_regular,
  input wire logic rom_done,
  input wire logic rom_od,
  input wire logic slot_req,
  input wire logic slot_wr,
  input wire logic slot_bit,
  input wire logic presence,
  input wire logic slot_done,
  input wire logic rd_bit,
  input wire logic overdrive_select
);
  // ==========================================================================
  // Helper: device sits right after reset, waiting for the ROM step
  logic fresh_q;  // Presence seen, ROM step not yet ended
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      fresh_q <= 1'b0;
    else if (presence)
      fresh_q <= 1'b1;
    else if (rom_done)
      fresh_q <= 1'b0;
  end
  // ==========================================================================
  // Properties, all in the one clock domain
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_wr_slot;
    slot_req && slot_wr;
  endsequence
  sequence s_od_rom;
    rom_done && rom_od;
  endsequence
  a_slot_answer: assert property (slot_req |=> slot_done)
    else $error("slot not answered next cycle");
  a_done_cause: assert property (slot_done |-> $past(slot_req))
    else $error("slot done without a slot");
  a_write_echo: assert property (s_wr_slot |=> rd_bit == $past(slot_bit))
    else $error("write slot level not echoed");
  a_bit_hold: assert property (!slot_done |-> $stable(rd_bit))
    else $error("read level moved outside a slot");
  a_pres_cause: assert property (presence |-> $past(rst_pulse))
    else $error("presence without reset pulse");
  a_od_enter: assert property ((fresh_q ##0 s_od_rom) |=> overdrive_select)
    else $error("overdrive not entered");
  a_od_rise: assert property ($rose(overdrive_select) |-> $past(rom_done && rom_od))
    else $error("overdrive rose without request");
  a_od_fall: assert property ($fell(overdrive_select) |-> $past(rst_pulse && rst_regular))
    else $error("overdrive left without regular reset");
endmodule

// ===== verification/tb.sv
// Self-checking bench: master and device joined, user side driven
`timescale 1ns/1ps
module tb;
  logic clk_sys, rstn, req_valid, req_od, rsp_valid, req_ready, od_active, copy_busy;
  logic [1:0]  req_op;
  logic [3:0]  req_nbits;
  logic [7:0]  req_data, rsp_data, ta_lo, ta_hi, es, lo, hi, es_x;
  logic [7:0]  sp [32];   // Data written in the current pass
  logic [15:0] crc;
  logic [31:0] lfsr = 32'h0001_62B2;
  int          fails, compares, off, n;
  time         t0;        // Start of the reset sent during a copy
  spm_link_if link (.clk_sys(clk_sys), .rstn(rstn));
  spm_device spm_device_inst (.clk_sys(clk_sys), .rstn(rstn), .link(link),
    .target_address_low(ta_lo), .target_address_high(ta_hi),
    .ending_offset_status(es), .copy_busy(copy_busy));
  spm_master spm_master_inst (.clk_sys(clk_sys), .rstn(rstn), .link(link),
    .req_valid(req_valid), .req_op(req_op), .req_data(req_data), .req_nbits(req_nbits),
    .req_od(req_od), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .od_active(od_active));
  spm_link_properties props (.clk_sys(clk_sys), .rstn(rstn), .rst_pulse(link.rst_pulse),
    .rst_regular(link.rst_regular), .rom_done(link.rom_done), .rom_od(link.rom_od),
    .slot_req(link.slot_req), .slot_wr(link.slot_wr), .slot_bit(link.slot_bit),
    .presence(link.presence), .slot_done(link.slot_done), .rd_bit(link.rd_bit),
    .overdrive_select(link.overdrive_select));
  // ==========================================================================
  // Expectation helpers: reflected CRC16 byte step and random source
  function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] b);
    for (int i = 0; i < 8; i++)
      c = (c[0] ^ b[i]) ? ((c >> 1) ^ spm_pkg::CRC_POLY) : (c >> 1);
    return c;
  endfunction
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction
  // ==========================================================================
  // Compare, user request, byte read, command start
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Called at a rising edge; request is taken at the next one
  task automatic req(input logic [1:0] op, input logic [7:0] d, input logic [3:0] nb,
                     input logic od);
    int i;
    req_valid <= 1'b1;
    req_op    <= op;
    req_data  <= d;
    req_nbits <= nb;
    req_od    <= od;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    i = 0;
    do
    begin
      @(posedge clk_sys);
      i++;
    end
    while (rsp_valid !== 1'b1 && i < 400);
    if (i >= 400)
      fails++;
  endtask
  task automatic rb(input logic [7:0] exp);
    req(2'd2, 8'h00, 4'd8, 1'b0);
    chk(rsp_data, exp);
  endtask
  task automatic start(input logic [7:0] cmd);
    req(2'd0, 8'h00, 4'd1, 1'b0);
    req(2'd1, cmd, 4'd8, 1'b0);
  endtask
  task automatic close_out();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================================================
  // Clock, watchdog well beyond the expected run
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial
  begin
    repeat (30000) @(posedge clk_sys);
    fails++;
    close_out();
  end
  // ==========================================================================
  // Main sequence: full write with CRC, partial write, copy, reads, speed
  initial
  begin
    {rstn, req_valid, req_op, req_data, req_nbits, req_od} = '0;
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    for (int p = 0; p < 2; p++)
    begin
      lo  = rnd();
      hi  = rnd();
      // Partial pass must stop short of offset 1FH, where the CRC takes over
      if (p == 1)
        lo[4] = 1'b0;
      off = lo[4:0];
      n   = (p == 0) ? 32 - off : 1 + rnd() % (31 - off);
      start(spm_pkg::CMD_WRITE_SP);
      crc = crc8(crc8(crc8(spm_pkg::CRC_INIT, spm_pkg::CMD_WRITE_SP), lo), hi);
      req(2'd1, lo, 4'd8, 1'b0);
      req(2'd1, hi, 4'd8, 1'b0);
      for (int k = 0; k < n; k++)
      begin
        sp[k] = rnd();
        crc   = crc8(crc, sp[k]);
        req(2'd1, sp[k], 4'd8, 1'b0);
      end
      // Full page answers with the inverted CRC; second pass ends on a partial byte
      if (p == 0)
      begin
        rb(~crc[7:0]);
        rb(~crc[15:8]);
      end
      else
      begin
        // write ends early, on a three-bit tail
        req(2'd1, 8'h05, 4'd3, 1'b0);
      end
      es_x = {2'b00, p[0], 5'(off + n - 1)};
      // read back and verify before copying
      start(spm_pkg::CMD_READ_SP);
      rb(lo);
      rb({7'h00, hi[0]});
      rb(es_x);
      for (int k = 0; k < n; k++)
        rb(sp[k]);
      if (p == 0)
        rb(spm_pkg::FILL_BYTE);
      chk(es, es_x);
      $display("write pass %0d done", p);
    end
    // Copy twice: first with a reset sent mid-copy, then the pattern is read
    for (int c = 0; c < 2; c++)
    begin
      start(spm_pkg::CMD_COPY_SP);
      req(2'd1, lo, 4'd8, 1'b0);
      req(2'd1, {7'h00, hi[0]}, 4'd8, 1'b0);
      req(2'd1, es_x | {c[0], 7'h00}, 4'd8, 1'b0);
      repeat (2) @(posedge clk_sys);
      chk({7'h00, copy_busy}, 8'h01);
      if (c == 0)
      begin
        t0 = $time;
        // reset only answered once the copy is over
        req(2'd0, 8'h00, 4'd1, 1'b0);
        chk({7'h00, ($time - t0) > spm_pkg::COPY_TIME_NS - 1000}, 8'h01);
      end
      for (int i = 0; i < 400 && copy_busy !== 1'b0; i++)
        @(posedge clk_sys);
      chk({7'h00, copy_busy}, 8'h00);
      chk(es, es_x | 8'h80);
    end
    rb(8'h55);
    start(spm_pkg::CMD_READ_MEM);
    req(2'd1, lo, 4'd8, 1'b0);
    req(2'd1, {7'h00, hi[0]}, 4'd8, 1'b0);
    for (int k = 0; k < n; k++)
      rb(sp[k]);
    chk(es, es_x | 8'h80);
    chk(ta_hi, {7'h00, hi[0]});
    chk(ta_lo, lo);
    $display("copy and read memory done");
    start(8'h33);
    rb(spm_pkg::FILL_BYTE);
    req(2'd0, 8'h00, 4'd1, 1'b1);
    // Speed flag follows the ROM step by one edge
    @(posedge clk_sys);
    chk({7'h00, od_active}, 8'h01);
    req(2'd0, 8'h00, 4'd1, 1'b0);
    chk({7'h00, od_active}, 8'h00);
    $display("command and speed tests done");
    close_out();
  end
endmodule
